// ### core/clock_activity_detect_and_select.v
// What this block does
// - base clock must fall in each external reference low phase; two misses flag inactive
// - internal inactive clears on base clock fall while external reference low
// - internal stable sets after two consecutive passing filter-stable measurements
// - internal stable clears on filter unstable, generator disabled, or internal inactive
// - external clock must fall in each internal reference low phase; two misses flag
// - external inactive clears on external clock fall while internal reference low
// - external stable sets after 4096 (crystal) or 16 external clock cycles
// - external stable clears on generator disable or external inactive
// - oscillator output follows external clock when source select is one
// - generator output clock is oscillator output divided by two
// - source select write accepted only with both generators on and target stable
// - timebase clock follows external clock when external on bit set and the monitor is not forcing internal
// - switch runs old clock 1-2 cycles, idles low 1-2 new cycles, then follows
// - reset selects internal clock
// - monitor on and inactive clock: force active clock, deselect dead side
// - forced selection of active clock lands 1-2 of its cycles later
// - clearing internal on bit ignored while internal clock is selected
// - each reference runs at most half the frequency of the clock it checks
`timescale 1ns/100ps
`include "clock_sel_defines.vh"

module clock_activity_detect_and_select
(
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire internal_osc_clock_i,
    input wire low_freq_base_clock_i,
    input wire external_source_clock_i,
    input wire external_derived_reference_i,
    input wire internal_derived_reference_i,
    input wire filter_stable_signal_i,
    input wire measure_done_i,
    input wire crystal_mode_option_i,
    input wire stop_i,
    input wire monitor_enable_bit_i,
    input wire source_select_wr_i,
    input wire source_select_wdata_i,
    input wire internal_on_bit_wr_i,
    input wire internal_on_bit_wdata_i,
    input wire external_on_bit_wr_i,
    input wire external_on_bit_wdata_i,
    output wire internal_inactive_indicator_o,
    output wire external_inactive_indicator_o,
    output reg internal_stable_flag_o,
    output reg external_stable_flag_o,
    output reg source_select_o,
    output reg internal_on_bit_o,
    output reg external_on_bit_o,
    output reg internal_generator_enable_o,
    output reg external_generator_enable_o,
    output wire oscillator_output_clock_o,
    output wire timebase_source_clock_o,
    output reg generator_output_clock_o
);

    reg [`SYNC_W-1:0] sync1_q;
    reg [`SYNC_W-1:0] sync2_q;
    reg [`SYNC_W-1:0] sync3_q;
    wire [`SYNC_W-1:0] fall;
    wire [`SYNC_W-1:0] rise;
    wire [1:0] watched_fall;
    wire [1:0] ref_lvl;
    wire [1:0] ref_rise;
    wire [1:0] inactive;
    reg [1:0] pass_cnt_q;
    reg [12:0] stab_cnt_q;
    wire [12:0] stab_limit;
    wire force_int;
    wire force_ext;
    wire target_stable;
    reg osc_prev_q;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // stage one feeds stage two only; stage three is the edge history
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1_q <= {`SYNC_W{1'b0}};
            sync2_q <= {`SYNC_W{1'b0}};
            sync3_q <= {`SYNC_W{1'b0}};
        end
        else if (ce_i)
        begin
            sync1_q <= {filter_stable_signal_i, internal_derived_reference_i,
                        external_derived_reference_i, internal_osc_clock_i,
                        external_source_clock_i, low_freq_base_clock_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // edge pulses on the synchronised levels
    assign fall = sync3_q & ~sync2_q;
    assign rise = ~sync3_q & sync2_q;

    // channel 0 checks the base clock, channel 1 checks the external clock
    assign watched_fall = {fall[`SYNC_EXT_CLK], fall[`SYNC_BASE_CLK]};
    assign ref_lvl = {sync2_q[`SYNC_INT_REF], sync2_q[`SYNC_EXT_REF]};
    assign ref_rise = {rise[`SYNC_INT_REF], rise[`SYNC_EXT_REF]};

    // ----------------------------------------------------------------
    // activity detectors
    // ----------------------------------------------------------------
    // a reference low phase ends at its rising edge; the verdict is taken
    // there. the checks only hold while each reference is at most half the
    // rate of the clock it watches, which the reference dividers ensure
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : det
            reg seen_q;
            reg inact_q;
            reg [1:0] miss_q;

            always @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    seen_q <= 1'b0;
                    inact_q <= 1'b0;
                    miss_q <= 2'h0;
                end
                else if (ce_i)
                begin
                    if (ref_rise[g])
                    begin
                        seen_q <= 1'b0;
                        if (seen_q)
                            miss_q <= 2'h0;
                        else if (miss_q != `MISS_LIMIT)
                            miss_q <= miss_q + 2'h1;
                        if (!seen_q && miss_q == `MISS_LIMIT - 2'h1)
                            inact_q <= 1'b1;
                    end
                    else if (watched_fall[g] && !ref_lvl[g])
                    begin
                        seen_q <= 1'b1;
                        inact_q <= 1'b0;
                    end
                end
            end

            assign inactive[g] = inact_q;
        end
    endgenerate

    assign internal_inactive_indicator_o = inactive[0];
    assign external_inactive_indicator_o = inactive[1];

    // ----------------------------------------------------------------
    // generator enables
    // ----------------------------------------------------------------
    // a generator runs while its on bit is set and the part is not stopped
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            internal_generator_enable_o <= 1'b0;
            external_generator_enable_o <= 1'b0;
        end
        else if (ce_i)
        begin
            internal_generator_enable_o <= internal_on_bit_o & ~stop_i;
            external_generator_enable_o <= external_on_bit_o & ~stop_i;
        end
    end

    // ----------------------------------------------------------------
    // internal stable flag
    // ----------------------------------------------------------------
    // measure_done_i marks the end of each frequency measurement
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pass_cnt_q <= 2'h0;
            internal_stable_flag_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!sync2_q[`SYNC_FILT_STABLE] || !internal_generator_enable_o || inactive[0])
            begin
                pass_cnt_q <= 2'h0;
                internal_stable_flag_o <= 1'b0;
            end
            else if (measure_done_i)
            begin
                if (pass_cnt_q == `PASS_LIMIT - 2'h1)
                    internal_stable_flag_o <= 1'b1;
                else
                    pass_cnt_q <= pass_cnt_q + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // external stable flag
    // ----------------------------------------------------------------
    // the stabilisation count restarts whenever the flag drops, so a clock
    // that recovers from inactivity is timed out again before use
    assign stab_limit = crystal_mode_option_i ? `STAB_XTAL_CYC : `STAB_EXT_CYC;

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stab_cnt_q <= 13'h0000;
            external_stable_flag_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!external_generator_enable_o || inactive[1])
            begin
                stab_cnt_q <= 13'h0000;
                external_stable_flag_o <= 1'b0;
            end
            else if (!external_stable_flag_o && fall[`SYNC_EXT_CLK])
            begin
                if (stab_cnt_q == stab_limit - 13'h0001)
                begin
                    stab_cnt_q <= 13'h0000;
                    external_stable_flag_o <= 1'b1;
                end
                else
                    stab_cnt_q <= stab_cnt_q + 13'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // control bits
    // ----------------------------------------------------------------
    // forcing by the monitor takes priority over a software write so the
    // select bit shows a live clock while the monitor is on and one clock is alive
    assign force_int = monitor_enable_bit_i & inactive[1];
    assign force_ext = monitor_enable_bit_i & inactive[0] & ~inactive[1];
    assign target_stable = source_select_wdata_i ? external_stable_flag_o : internal_stable_flag_o;

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            source_select_o <= `RST_SOURCE_SELECT;
            internal_on_bit_o <= `RST_INTERNAL_ON;
            external_on_bit_o <= `RST_EXTERNAL_ON;
        end
        else if (ce_i)
        begin
            if (force_int)
                source_select_o <= 1'b0;
            else if (force_ext)
                source_select_o <= 1'b1;
            else if (source_select_wr_i && internal_generator_enable_o &&
                     external_generator_enable_o && target_stable)
                source_select_o <= source_select_wdata_i;
            if (internal_on_bit_wr_i && (internal_on_bit_wdata_i || source_select_o))
                internal_on_bit_o <= internal_on_bit_wdata_i;
            if (external_on_bit_wr_i)
                external_on_bit_o <= external_on_bit_wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // clock switches
    // ----------------------------------------------------------------
    // the dead side's synchroniser is cleared at once; the live side still
    // walks its two stages, giving the 1 to 2 cycle delay on a forced swap
    glitch_free_switch osc_switch
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .a_lvl_i(sync2_q[`SYNC_INT_CLK]),
        .a_fall_i(fall[`SYNC_INT_CLK]),
        .b_lvl_i(sync2_q[`SYNC_EXT_CLK]),
        .b_fall_i(fall[`SYNC_EXT_CLK]),
        .sel_b_i(source_select_o),
        .kill_a_i(force_ext),
        .kill_b_i(force_int),
        .clk_o(oscillator_output_clock_o)
    );

    // timebase follows the on bit directly, stable or not, unless forced
    glitch_free_switch tb_switch
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .a_lvl_i(sync2_q[`SYNC_INT_CLK]),
        .a_fall_i(fall[`SYNC_INT_CLK]),
        .b_lvl_i(sync2_q[`SYNC_EXT_CLK]),
        .b_fall_i(fall[`SYNC_EXT_CLK]),
        .sel_b_i((external_on_bit_o | force_ext) & ~force_int),
        .kill_a_i(force_ext),
        .kill_b_i(force_int),
        .clk_o(timebase_source_clock_o)
    );

    // ----------------------------------------------------------------
    // divide by two
    // ----------------------------------------------------------------
    // toggles on each rising edge of the oscillator output clock
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            osc_prev_q <= 1'b0;
            generator_output_clock_o <= 1'b0;
        end
        else if (ce_i)
        begin
            osc_prev_q <= oscillator_output_clock_o;
            if (oscillator_output_clock_o && !osc_prev_q)
                generator_output_clock_o <= ~generator_output_clock_o;
        end
    end

endmodule

// ### core/clock_sel_defines.vh
`ifndef CLOCK_SEL_DEFINES_VH
`define CLOCK_SEL_DEFINES_VH

// ----------------------------------------------------------------
// synchroniser vector layout
// ----------------------------------------------------------------
`define SYNC_W 6
`define SYNC_BASE_CLK 0
`define SYNC_EXT_CLK 1
`define SYNC_INT_CLK 2
`define SYNC_EXT_REF 3
`define SYNC_INT_REF 4
`define SYNC_FILT_STABLE 5

// ----------------------------------------------------------------
// activity detector and stable flag counts
// ----------------------------------------------------------------
`define MISS_LIMIT 2'h2
`define PASS_LIMIT 2'h2
`define STAB_XTAL_CYC 13'h1000
`define STAB_EXT_CYC 13'h0010

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SOURCE_SELECT 1'h0
`define RST_INTERNAL_ON 1'h1
`define RST_EXTERNAL_ON 1'h0

`endif

// ### core/glitch_free_switch.v
`timescale 1ns/100ps
`include "clock_sel_defines.vh"

// two-input clock switch on oversampled clock levels; side a is the
// internal clock and is the side selected out of reset
module glitch_free_switch
(
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire a_lvl_i,
    input wire a_fall_i,
    input wire b_lvl_i,
    input wire b_fall_i,
    input wire sel_b_i,
    input wire kill_a_i,
    input wire kill_b_i,
    output reg clk_o
);

    reg a_s1_q;
    reg a_s2_q;
    reg b_s1_q;
    reg b_s2_q;

    // ----------------------------------------------------------------
    // per-side select synchronisers, each stepped by its own clock
    // ----------------------------------------------------------------
    // each side only enables once the other side's final stage is off,
    // so the output idles low between the last old and first new pulse
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            a_s1_q <= 1'b1;
            a_s2_q <= 1'b1;
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
        end
        else if (ce_i)
        begin
            // a dead clock cannot step its stage, so it is cleared outright
            if (kill_a_i)
            begin
                a_s1_q <= 1'b0;
                a_s2_q <= 1'b0;
            end
            else if (a_fall_i)
            begin
                a_s1_q <= ~sel_b_i & ~b_s2_q;
                a_s2_q <= a_s1_q;
            end
            if (kill_b_i)
            begin
                b_s1_q <= 1'b0;
                b_s2_q <= 1'b0;
            end
            else if (b_fall_i)
            begin
                b_s1_q <= sel_b_i & ~a_s2_q;
                b_s2_q <= b_s1_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // gated output, registered
    // ----------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            clk_o <= 1'b0;
        else if (ce_i)
            clk_o <= (a_lvl_i & a_s2_q) | (b_lvl_i & b_s2_q);
    end

endmodule

// ### dv/clock_select_monitor.sv
`timescale 1ns/100ps

// watches switch interlocks, forcing and flag clearing at the block's ports
module clock_select_monitor
(
    input logic clk_i,
    input logic rst_i,
    input logic monitor_enable_bit_i,
    input logic source_select_wr_i,
    input logic source_select_wdata_i,
    input logic internal_on_bit_wr_i,
    input logic internal_on_bit_wdata_i,
    input logic external_source_clock_i,
    input logic internal_inactive_indicator_o,
    input logic external_inactive_indicator_o,
    input logic internal_stable_flag_o,
    input logic external_stable_flag_o,
    input logic source_select_o,
    input logic internal_on_bit_o,
    input logic external_on_bit_o,
    input logic internal_generator_enable_o,
    input logic external_generator_enable_o,
    input logic oscillator_output_clock_o,
    input logic timebase_source_clock_o,
    input logic generator_output_clock_o
);
    logic [7:0] age_q;
    wire sel_ok = internal_generator_enable_o && external_generator_enable_o
                  && (source_select_wdata_i ? external_stable_flag_o : internal_stable_flag_o);

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // cycles since either switch select last moved, saturating
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            age_q <= 8'h00;
        else if ($changed(source_select_o) || $changed(external_on_bit_o) || $changed(monitor_enable_bit_i))
            age_q <= 8'h00;
        else if (age_q != 8'hFF)
            age_q <= age_q + 8'h01;
    end

    rst_state_a: assert property (disable iff (1'b0) rst_i |-> !source_select_o && internal_on_bit_o)
        else $error("reset state wrong");
    div_toggle_a: assert property ($rose(oscillator_output_clock_o) |=> $changed(generator_output_clock_o))
        else $error("divider missed a toggle");
    sel_refuse_a: assert property (source_select_wr_i && !monitor_enable_bit_i && !sel_ok
        |=> $stable(source_select_o)) else $error("select write taken without interlock");
    sel_take_a: assert property (source_select_wr_i && !monitor_enable_bit_i && sel_ok
        |=> source_select_o == $past(source_select_wdata_i)) else $error("select write lost");
    int_off_hold_a: assert property (internal_on_bit_wr_i && !internal_on_bit_wdata_i && !source_select_o
        && internal_on_bit_o |=> internal_on_bit_o) else $error("internal on cleared while selected");
    ext_flag_clr_a: assert property (!external_generator_enable_o || external_inactive_indicator_o
        |=> !external_stable_flag_o) else $error("external stable not cleared");
    int_flag_clr_a: assert property (!internal_generator_enable_o || internal_inactive_indicator_o
        |=> !internal_stable_flag_o) else $error("internal stable not cleared");
    force_int_a: assert property (monitor_enable_bit_i && external_inactive_indicator_o
        |=> !source_select_o) else $error("dead external not deselected");
    force_ext_a: assert property (monitor_enable_bit_i && internal_inactive_indicator_o
        && !external_inactive_indicator_o |=> source_select_o) else $error("dead internal not deselected");
    osc_follow_a: assert property ((source_select_o && age_q == 8'hFF && !external_source_clock_i) [*6]
        |-> !oscillator_output_clock_o) else $error("oscillator output not on external clock");
    tb_follow_a: assert property ((external_on_bit_o && !monitor_enable_bit_i && age_q == 8'hFF
        && !external_source_clock_i) [*6] |-> !timebase_source_clock_o) else $error("timebase not on external");
endmodule

bind clock_activity_detect_and_select clock_select_monitor u_monitor
(
    .clk_i, .rst_i, .monitor_enable_bit_i, .source_select_wr_i, .source_select_wdata_i, .internal_on_bit_wr_i,
    .internal_on_bit_wdata_i, .external_source_clock_i, .internal_inactive_indicator_o,
    .external_inactive_indicator_o, .internal_stable_flag_o, .external_stable_flag_o, .source_select_o,
    .internal_on_bit_o, .external_on_bit_o, .internal_generator_enable_o, .external_generator_enable_o,
    .oscillator_output_clock_o, .timebase_source_clock_o, .generator_output_clock_o
);

// ### dv/clock_source_model.sv
`timescale 1ns/100ps

// internal oscillator and external source; a stopped source holds its level
module clock_source_model
(
    input wire clk_i,
    input wire rst_i,
    input wire int_run_i,
    input wire ext_run_i,
    output wire internal_osc_clock_o,
    output wire low_freq_base_clock_o,
    output wire internal_derived_reference_o,
    output wire external_source_clock_o,
    output wire external_derived_reference_o,
    output wire measure_done_o
);
    reg [7:0] int_cnt_q;
    reg [5:0] ext_cnt_q;

    // each source advances only while it runs
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            int_cnt_q <= 8'h00;
            ext_cnt_q <= 6'h00;
        end
        else
        begin
            if (int_run_i)
                int_cnt_q <= int_cnt_q + 8'h01;
            if (ext_run_i)
                ext_cnt_q <= ext_cnt_q + 6'h01;
        end
    end

    // references at least four times slower than the clock they check
    assign internal_osc_clock_o = int_cnt_q[2];
    assign low_freq_base_clock_o = int_cnt_q[3];
    assign internal_derived_reference_o = int_cnt_q[7];
    assign external_source_clock_o = ext_cnt_q[2];
    assign external_derived_reference_o = ext_cnt_q[5];
    assign measure_done_o = int_run_i && (int_cnt_q[5:0] == 6'h3F);
endmodule

// ### dv/clock_activity_detect_and_select_test.sv
`timescale 1ns/100ps

module clock_activity_detect_and_select_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b0;
    logic filter_stable_signal_i = 1'b1;
    logic crystal_mode_option_i = 1'b0;
    logic stop_i = 1'b0;
    logic monitor_enable_bit_i = 1'b0;
    logic source_select_wr_i = 1'b0;
    logic source_select_wdata_i = 1'b0;
    logic internal_on_bit_wr_i = 1'b0;
    logic internal_on_bit_wdata_i = 1'b0;
    logic external_on_bit_wr_i = 1'b0;
    logic external_on_bit_wdata_i = 1'b0;
    logic int_run = 1'b1;
    logic ext_run = 1'b1;
    logic internal_osc_clock_i, low_freq_base_clock_i, external_source_clock_i, measure_done_i;
    logic external_derived_reference_i, internal_derived_reference_i;
    logic internal_inactive_indicator_o, external_inactive_indicator_o, internal_stable_flag_o;
    logic external_stable_flag_o, source_select_o, internal_on_bit_o, external_on_bit_o;
    logic internal_generator_enable_o, external_generator_enable_o;
    logic oscillator_output_clock_o, timebase_source_clock_o, generator_output_clock_o;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;

    always #2 clk_i = ~clk_i;

    clock_activity_detect_and_select u_dut
    (
        .clk_i, .rst_i, .ce_i(1'b1), .internal_osc_clock_i, .low_freq_base_clock_i, .external_source_clock_i,
        .external_derived_reference_i, .internal_derived_reference_i, .filter_stable_signal_i, .measure_done_i,
        .crystal_mode_option_i, .stop_i, .monitor_enable_bit_i, .source_select_wr_i, .source_select_wdata_i,
        .internal_on_bit_wr_i, .internal_on_bit_wdata_i, .external_on_bit_wr_i, .external_on_bit_wdata_i,
        .internal_inactive_indicator_o, .external_inactive_indicator_o, .internal_stable_flag_o,
        .external_stable_flag_o, .source_select_o, .internal_on_bit_o, .external_on_bit_o,
        .internal_generator_enable_o, .external_generator_enable_o, .oscillator_output_clock_o,
        .timebase_source_clock_o, .generator_output_clock_o
    );

    // sources stop when their generator is disabled
    clock_source_model u_src
    (
        .clk_i, .rst_i, .int_run_i(int_run && internal_generator_enable_o),
        .ext_run_i(ext_run && external_generator_enable_o), .internal_osc_clock_o(internal_osc_clock_i),
        .low_freq_base_clock_o(low_freq_base_clock_i), .internal_derived_reference_o(internal_derived_reference_i),
        .external_source_clock_o(external_source_clock_i),
        .external_derived_reference_o(external_derived_reference_i), .measure_done_o(measure_done_i)
    );

    task report_and_stop();
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task check(input string what, input logic seen, input logic exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    function logic pick(input int k);
        case (k)
            0: pick = internal_inactive_indicator_o;
            1: pick = external_inactive_indicator_o;
            2: pick = internal_stable_flag_o;
            3: pick = external_stable_flag_o;
            4: pick = source_select_o;
            5: pick = internal_on_bit_o;
            default: pick = external_on_bit_o;
        endcase
    endfunction

    // wait up to lim cycles for a status bit, then judge it
    task wait_chk(input string what, input int k, input logic v, input int lim);
        int n;
        n = 0;
        @(negedge clk_i);
        while (pick(k) !== v && n < lim)
        begin
            @(negedge clk_i);
            n++;
        end
        check(what, pick(k), v);
    endtask

    // one-cycle write pulse: 0 select, 1 internal on, 2 external on
    task wr(input int k, input logic d);
        @(posedge clk_i);
        source_select_wr_i <= (k == 0);
        internal_on_bit_wr_i <= (k == 1);
        external_on_bit_wr_i <= (k == 2);
        source_select_wdata_i <= d;
        internal_on_bit_wdata_i <= d;
        external_on_bit_wdata_i <= d;
        @(posedge clk_i);
        source_select_wr_i <= 1'b0;
        internal_on_bit_wr_i <= 1'b0;
        external_on_bit_wr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // reset state; internal flag settles
    task t_boot();
        wait_chk("select", 4, 1'b0, 0);
        wait_chk("int_on", 5, 1'b1, 0);
        wait_chk("ext_on", 6, 1'b0, 0);
        wait_chk("int_stable", 2, 1'b1, 400);
    endtask

    // early switch refused; external flag after 16 clock cycles
    task t_ext_on();
        wr(2, 1'b1);
        wr(0, 1'b1);
        wait_chk("early select", 4, 1'b0, 0);
        repeat (100) @(posedge clk_i);
        wait_chk("ext_stable early", 3, 1'b0, 0);
        wait_chk("ext_stable", 3, 1'b1, 100);
    endtask

    // enable, wait, switch, disable old source, and back
    task t_switch();
        wr(1, 1'b0);
        wait_chk("int_on held", 5, 1'b1, 0);
        wr(0, 1'b1);
        wait_chk("select ext", 4, 1'b1, 0);
        wr(1, 1'b0);
        wait_chk("int_on off", 5, 1'b0, 0);
        wr(0, 1'b0);
        wait_chk("select held", 4, 1'b1, 0);
        repeat (300) @(posedge clk_i);
        wait_chk("int_stable off", 2, 1'b0, 0);
        wr(1, 1'b1);
        wait_chk("int_stable again", 2, 1'b1, 400);
        wr(0, 1'b0);
        wait_chk("select int", 4, 1'b0, 0);
    endtask

    // external source dies under the monitor
    task t_ext_dead();
        wr(0, 1'b1);
        @(posedge clk_i) monitor_enable_bit_i <= 1'b1;
        @(posedge clk_i) ext_run <= 1'b0;
        wait_chk("ext_inactive", 1, 1'b1, 800);
        repeat (2) @(posedge clk_i);
        wait_chk("forced int", 4, 1'b0, 0);
        wait_chk("ext_stable lost", 3, 1'b0, 0);
        @(posedge clk_i) ext_run <= 1'b1;
        wait_chk("ext_inactive clear", 1, 1'b0, 400);
        @(posedge clk_i) monitor_enable_bit_i <= 1'b0;
        wait_chk("ext_stable back", 3, 1'b1, 400);
    endtask

    // internal source dies under the monitor
    task t_int_dead();
        @(posedge clk_i) monitor_enable_bit_i <= 1'b1;
        @(posedge clk_i) int_run <= 1'b0;
        wait_chk("int_inactive", 0, 1'b1, 400);
        repeat (2) @(posedge clk_i);
        wait_chk("int_stable lost", 2, 1'b0, 0);
        wait_chk("forced ext", 4, 1'b1, 0);
        @(posedge clk_i) int_run <= 1'b1;
        wait_chk("int_inactive clear", 0, 1'b0, 200);
        @(posedge clk_i) monitor_enable_bit_i <= 1'b0;
        wait_chk("int_stable back", 2, 1'b1, 400);
        wr(0, 1'b0);
    endtask

    // filter instability and stop mode drop the stable flags
    task t_filter_stop();
        @(posedge clk_i) filter_stable_signal_i <= 1'b0;
        wait_chk("int_stable filter", 2, 1'b0, 10);
        @(posedge clk_i) filter_stable_signal_i <= 1'b1;
        @(posedge clk_i) stop_i <= 1'b1;
        wait_chk("ext_stable stop", 3, 1'b0, 10);
        @(posedge clk_i) stop_i <= 1'b0;
        wait_chk("ext_stable after stop", 3, 1'b1, 400);
    endtask

    // crystal mode stretches the settling count to 4096 cycles
    task t_crystal();
        @(posedge clk_i) crystal_mode_option_i <= 1'b1;
        wr(2, 1'b0);
        wr(2, 1'b1);
        repeat (31500) @(posedge clk_i);
        wait_chk("xtal early", 3, 1'b0, 0);
        wait_chk("xtal stable", 3, 1'b1, 2500);
    endtask

    // cut a hang short
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 50000)
        begin
            fail_count = fail_count + 1;
            report_and_stop();
        end
    end

    // main sequence
    initial
    begin
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_ext_on();
        t_switch();
        t_ext_dead();
        t_int_dead();
        t_filter_stop();
        t_crystal();
        report_and_stop();
    end
endmodule
